// [design/blc_config_regs.sv]
// Two-wire serial slave and configuration register bank of the controller
`default_nettype none

module blc_config_regs #(
  parameter logic [7:0] MAKER_CODE = 8'hA5 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Serial bus pins, data is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Analog side
  input wire logic [5:0] fault_in,
  input wire logic [9:0] ext_duty_code,
  // Decoded settings and raw register codes
  output logic [3:0] string_enable,
  output logic amplitude_active,
  output logic internal_pwm_active,
  output logic [9:0] dim_level,
  output logic recover_auto,
  output logic [3:0] short_volts,
  output logic converter_on,
  output logic [3:0] freq_step_100k,
  output logic [7:0] full_scale_code,
  output logic [7:0] prot_thresh_code
);

  // Pin synchronisers, first stage read only by second
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [5:0] fault_s1_reg;
  logic [5:0] fault_s2_reg;
  logic scl_d_reg;
  logic sda_d_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      fault_s1_reg <= 6'h00;
      fault_s2_reg <= 6'h00;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      fault_s1_reg <= fault_in;
      fault_s2_reg <= fault_s1_reg;
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  // Bus events from the synchronised levels
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s && !scl_d_reg;
  wire scl_fall = !scl_s && scl_d_reg;
  wire start_cond = scl_s && scl_d_reg && !sda_s && sda_d_reg;
  wire stop_cond = scl_s && scl_d_reg && sda_s && !sda_d_reg;

  // Register storage
  blc_pkg::blc_dim_ctrl_t dim_ctrl_reg;
  blc_pkg::blc_freq_prot_t freq_prot_reg;
  logic [7:0] full_scale_reg;
  logic [1:0] brt_lo_reg;
  logic [7:0] brt_hi_reg;
  logic [7:0] prot_thresh_reg;

  // Serial engine state
  blc_pkg::blc_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic nack_reg;
  logic sda_oe_reg;

  // Read data selection by register index
  wire [7:0] fault_brt_lo = {fault_s2_reg, brt_lo_reg};
  logic [7:0] rd_data;
  assign rd_data =
    (ptr_reg == blc_pkg::IDX_DIM_CTRL) ? dim_ctrl_reg :
    (ptr_reg == blc_pkg::IDX_FREQ_PROT) ? freq_prot_reg :
    (ptr_reg == blc_pkg::IDX_FULL_SCALE) ? full_scale_reg :
    (ptr_reg == blc_pkg::IDX_FAULT_BRT_LO) ? fault_brt_lo :
    (ptr_reg == blc_pkg::IDX_BRT_HI) ? brt_hi_reg :
    (ptr_reg == blc_pkg::IDX_PROT_THRESH) ? prot_thresh_reg :
    (ptr_reg == blc_pkg::IDX_MAKER_ID) ? MAKER_CODE : 8'h00;

  // Engine decode
  wire byte_done = (bit_cnt_reg == 4'(blc_pkg::BIT_CNT_FULL));
  wire addr_hit = (shift_reg[7:1] == blc_pkg::DEV_ADDR);
  wire wr_strobe = scl_fall && byte_done && (state_reg == blc_pkg::ST_WDATA);
  wire [7:0] ptr_inc = ptr_reg + 8'h01;

  // Serial engine; data changes on clock fall, sampled on clock rise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= blc_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg <= blc_pkg::ST_ADDR; // Repeated start too
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_cond) begin
      state_reg <= blc_pkg::ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (scl_rise) begin
      case (state_reg)
        blc_pkg::ST_ADDR, blc_pkg::ST_PTR, blc_pkg::ST_WDATA: begin
          shift_reg <= {shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        blc_pkg::ST_RDATA: bit_cnt_reg <= bit_cnt_reg + 4'h1;
        blc_pkg::ST_RDATA_ACK: nack_reg <= sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_reg)
        blc_pkg::ST_ADDR: begin
          if (byte_done) begin
            rw_reg <= shift_reg[0];
            if (addr_hit) begin
              state_reg <= blc_pkg::ST_ADDR_ACK;
              sda_oe_reg <= 1'b1;
            end else begin
              state_reg <= blc_pkg::ST_IDLE;
            end
          end
        end
        blc_pkg::ST_ADDR_ACK: begin
          bit_cnt_reg <= 4'h0;
          if (rw_reg) begin
            state_reg <= blc_pkg::ST_RDATA;
            shift_reg <= rd_data;
            sda_oe_reg <= !rd_data[7];
          end else begin
            state_reg <= blc_pkg::ST_PTR;
            sda_oe_reg <= 1'b0;
          end
        end
        blc_pkg::ST_PTR: begin
          if (byte_done) begin
            ptr_reg <= shift_reg;
            state_reg <= blc_pkg::ST_PTR_ACK;
            sda_oe_reg <= 1'b1;
          end
        end
        blc_pkg::ST_PTR_ACK, blc_pkg::ST_WDATA_ACK: begin
          state_reg <= blc_pkg::ST_WDATA;
          bit_cnt_reg <= 4'h0;
          sda_oe_reg <= 1'b0;
        end
        blc_pkg::ST_WDATA: begin
          if (byte_done) begin
            ptr_reg <= ptr_inc; // Next byte lands on next index
            state_reg <= blc_pkg::ST_WDATA_ACK;
            sda_oe_reg <= 1'b1;
          end
        end
        blc_pkg::ST_RDATA: begin
          if (byte_done) begin
            ptr_reg <= ptr_inc;
            state_reg <= blc_pkg::ST_RDATA_ACK;
            sda_oe_reg <= 1'b0; // Master owns the ack bit
          end else begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            sda_oe_reg <= !shift_reg[6];
          end
        end
        blc_pkg::ST_RDATA_ACK: begin
          bit_cnt_reg <= 4'h0;
          if (nack_reg) begin
            state_reg <= blc_pkg::ST_IDLE;
          end else begin
            state_reg <= blc_pkg::ST_RDATA;
            shift_reg <= rd_data;
            sda_oe_reg <= !rd_data[7];
          end
        end
        default: ;
      endcase
    end
  end

  // Register writes; unmapped and read-only indices drop the byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dim_ctrl_reg <= blc_pkg::RST_DIM_CTRL;
      freq_prot_reg <= blc_pkg::RST_FREQ_PROT;
      full_scale_reg <= blc_pkg::RST_FULL_SCALE;
      brt_lo_reg <= blc_pkg::RST_BRT_LO;
      brt_hi_reg <= blc_pkg::RST_BRT_HI;
      prot_thresh_reg <= blc_pkg::RST_PROT_THRESH;
    end else if (wr_strobe) begin
      case (ptr_reg)
        blc_pkg::IDX_DIM_CTRL: dim_ctrl_reg <= shift_reg;
        blc_pkg::IDX_FREQ_PROT: freq_prot_reg <= shift_reg;
        blc_pkg::IDX_FULL_SCALE: full_scale_reg <= shift_reg;
        blc_pkg::IDX_FAULT_BRT_LO: brt_lo_reg <= shift_reg[1:0];
        blc_pkg::IDX_BRT_HI: brt_hi_reg <= shift_reg;
        blc_pkg::IDX_PROT_THRESH: prot_thresh_reg <= shift_reg;
        default: ;
      endcase
    end
  end

  // Pin drive and raw register outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      full_scale_code <= blc_pkg::RST_FULL_SCALE;
      prot_thresh_code <= blc_pkg::RST_PROT_THRESH;
    end else begin
      sda_out <= 1'b0; // Open drain only pulls low
      sda_oe <= sda_oe_reg;
      full_scale_code <= full_scale_reg;
      prot_thresh_code <= prot_thresh_reg;
    end
  end

  // Setting decoder
  blc_dim_decode u_decode (
    .clk(clk),
    .arst_n(arst_n),
    .dim_ctrl(dim_ctrl_reg),
    .freq_prot(freq_prot_reg),
    .brightness_code({brt_hi_reg, brt_lo_reg}),
    .ext_duty_code(ext_duty_code),
    .string_enable(string_enable),
    .amplitude_active(amplitude_active),
    .internal_pwm_active(internal_pwm_active),
    .dim_level(dim_level),
    .recover_auto(recover_auto),
    .short_volts(short_volts),
    .converter_on(converter_on),
    .freq_step_100k(freq_step_100k)
  );

endmodule : blc_config_regs

`default_nettype wire

// [design/blc_dim_decode.sv]
// Dimming, frequency and protection setting decoder
`default_nettype none

module blc_dim_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register contents and external duty code
  input wire blc_pkg::blc_dim_ctrl_t dim_ctrl,
  input wire blc_pkg::blc_freq_prot_t freq_prot,
  input wire logic [9:0] brightness_code,
  input wire logic [9:0] ext_duty_code,
  // Decoded controls
  output logic [3:0] string_enable,
  output logic amplitude_active,
  output logic internal_pwm_active,
  output logic [9:0] dim_level,
  output logic recover_auto,
  output logic [3:0] short_volts,
  output logic converter_on,
  output logic [3:0] freq_step_100k
);

  // Source and mode decode
  wire [1:0] mode = {dim_ctrl.dim_mode_bit1, dim_ctrl.dim_mode_bit0};
  wire use_reg = dim_ctrl.src_reg;
  wire [9:0] duty = use_reg ? brightness_code : ext_duty_code;
  wire over25 = blc_pkg::above_point(duty, blc_pkg::POINT_25);
  wire over50 = blc_pkg::above_point(duty, blc_pkg::POINT_50);
  wire mix_mode = (mode == blc_pkg::MODE_MIX25) ||
                  (mode == blc_pkg::MODE_MIX50);
  wire mix_amp = (mode == blc_pkg::MODE_MIX25) ? over25 : over50;
  wire amp_next = (mode == blc_pkg::MODE_AMPL) || (mix_mode && mix_amp);
  // Below the transfer point the 23 kHz generator runs whatever the source
  wire int_pwm_next = ((mode == blc_pkg::MODE_PULSE) && use_reg) ||
                      (mix_mode && !mix_amp);
  // Codes above 1001 have no frequency, so they keep the converter off
  wire conv_next = (freq_prot.switch_frequency_code != 4'h0) &&
    (freq_prot.switch_frequency_code <= blc_pkg::FREQ_CODE_MAX);
  wire [3:0] volts_next = blc_pkg::SHORT_BASE_V +
    {1'b0, freq_prot.short_threshold_code};

  // Registered outputs; spare bit deliberately unused
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      string_enable <= 4'hF;
      amplitude_active <= 1'b0;
      internal_pwm_active <= 1'b0;
      dim_level <= 10'h000;
      recover_auto <= 1'b0;
      short_volts <= 4'h8;
      converter_on <= 1'b1;
      freq_step_100k <= 4'h4;
    end else begin
      string_enable <= dim_ctrl.string_source_enables;
      amplitude_active <= amp_next;
      internal_pwm_active <= int_pwm_next;
      dim_level <= duty;
      recover_auto <= freq_prot.current_limit_recovery_select;
      short_volts <= volts_next;
      converter_on <= conv_next;
      freq_step_100k <= conv_next ? freq_prot.switch_frequency_code : 4'h0;
    end
  end

endmodule : blc_dim_decode

`default_nettype wire

// [design/blc_pkg.sv]
// Shared constants and types of the backlight configuration register bank
`default_nettype none

package blc_pkg;

  // Bus address of the device
  localparam logic [6:0] DEV_ADDR = 7'h31;

  // Register indices
  localparam logic [7:0] IDX_DIM_CTRL = 8'h00;
  localparam logic [7:0] IDX_FREQ_PROT = 8'h01;
  localparam logic [7:0] IDX_FULL_SCALE = 8'h02;
  localparam logic [7:0] IDX_FAULT_BRT_LO = 8'h03;
  localparam logic [7:0] IDX_BRT_HI = 8'h04;
  localparam logic [7:0] IDX_PROT_THRESH = 8'h05;
  localparam logic [7:0] IDX_MAKER_ID = 8'h06;

  // Reset values
  localparam logic [7:0] RST_DIM_CTRL = 8'hF0;
  localparam logic [7:0] RST_FREQ_PROT = 8'h44;
  localparam logic [7:0] RST_FULL_SCALE = 8'h3B;
  localparam logic [1:0] RST_BRT_LO = 2'h3;
  localparam logic [7:0] RST_BRT_HI = 8'h7F;
  localparam logic [7:0] RST_PROT_THRESH = 8'hE7;

  // Fault field position and bit count of a full byte
  localparam int FAULT_LSB = 2;
  localparam int BIT_CNT_FULL = 8;

  // Mode encodings of the dimming control register
  localparam logic [1:0] MODE_PULSE = 2'h0;
  localparam logic [1:0] MODE_AMPL = 2'h1;
  localparam logic [1:0] MODE_MIX25 = 2'h2;
  localparam logic [1:0] MODE_MIX50 = 2'h3;

  // Transfer points on the 10-bit duty scale, 1024 = full
  localparam logic [9:0] POINT_25 = 10'h100;
  localparam logic [9:0] POINT_50 = 10'h200;

  // Short threshold base and highest valid frequency code
  localparam logic [3:0] SHORT_BASE_V = 4'h4;
  localparam logic [3:0] FREQ_CODE_MAX = 4'h9;

  // Dimming control register layout
  typedef struct packed {
    logic [3:0] string_source_enables;
    logic spare;
    logic src_reg;
    logic dim_mode_bit1;
    logic dim_mode_bit0;
  } blc_dim_ctrl_t;

  // Frequency and protection mode register layout
  typedef struct packed {
    logic current_limit_recovery_select;
    logic [2:0] short_threshold_code;
    logic [3:0] switch_frequency_code;
  } blc_freq_prot_t;

  // Serial engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } blc_state_t;

  // Whether a duty lies strictly above a transfer point
  function automatic logic above_point(input logic [9:0] duty,
                                       input logic [9:0] point);
    above_point = (duty > point);
  endfunction : above_point

endpackage : blc_pkg

`default_nettype wire

// [dv/blc_bus_master.sv]
// Two-wire bus master model facing the register bank
`default_nettype none

module blc_bus_master (
  // Clock
  input wire logic clk,
  // Bus wires, data released means pulled up
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  int q = 8; // Quarter bit in clk cycles; raise for a slow master

  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // Quarter bit wait, stepping just off the edge
  task automatic wq();
    repeat (q) @(posedge clk);
    #1;
  endtask : wq

  // Start or repeated start: data falls while clock high
  task automatic start();
    sda_oe = 1'b0;
    wq();
    scl = 1'b1;
    wq();
    sda_oe = 1'b1;
    wq();
    scl = 1'b0;
    wq();
  endtask : start

  // Stop: data rises while clock high, clock then stands high
  task automatic stop();
    sda_oe = 1'b1;
    wq();
    scl = 1'b1;
    wq();
    sda_oe = 1'b0;
    wq();
  endtask : stop

  // One clock pulse, line sampled mid high phase
  task automatic pulse(output logic s);
    wq();
    scl = 1'b1;
    wq();
    s = sda;
    wq();
    scl = 1'b0;
    wq();
  endtask : pulse

  // Byte out MSB first; ninth clock returns the device's answer
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_oe = ~b[i];
      pulse(s);
    end
    sda_oe = 1'b0;
    pulse(s);
    ack = ~s;
  endtask : send

  // Byte in MSB first, then our acknowledge or its absence
  task automatic recv(output logic [7:0] b, input logic nack);
    logic s;
    sda_oe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    sda_oe = ~nack;
    pulse(s);
  endtask : recv
endmodule : blc_bus_master

`default_nettype wire

// [dv/blc_cfg_chk_asserts.sv]
// Assertion checker for the configuration register bank ports
`default_nettype none

module blc_cfg_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Decoded settings
  input wire logic [3:0] string_enable,
  input wire logic amplitude_active,
  input wire logic internal_pwm_active,
  input wire logic recover_auto,
  input wire logic [3:0] short_volts,
  input wire logic converter_on,
  input wire logic [3:0] freq_step_100k
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Open-drain pin: only ever pulls low, changes while the clock is low
  a_sda_out_low: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed while bus clock high");
  a_oe_bit_hold: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("data pull dropped inside a bit");
  a_quiet_reset: assert property ($rose(arst_n) |-> !sda_oe [*4])
    else $error("data pulled right after reset");
  // Power-up settings seen at the first sampled edge
  a_reset_defaults: assert property ($rose(arst_n) |->
    string_enable == 4'hF && !recover_auto && short_volts == 4'h8
    && freq_step_100k == 4'h4 && converter_on)
    else $error("power-up settings wrong");
  // Frequency steps 1 to 9 only while the converter runs
  a_freq_on_range: assert property (converter_on |->
    freq_step_100k inside {[4'h1:4'h9]})
    else $error("running frequency out of range");
  a_freq_off_zero: assert property (!converter_on |->
    freq_step_100k == 4'h0)
    else $error("stopped converter shows a frequency");
  a_short_range: assert property (short_volts inside {[4'h4:4'hB]})
    else $error("short threshold out of range");
  // Amplitude and internal pulse dimming never both in force
  a_mode_excl: assert property (!(amplitude_active &&
    internal_pwm_active))
    else $error("two dimming kinds at once");

  c_ack: cover property ($rose(sda_oe));
  c_amp: cover property (amplitude_active);
  c_ipwm: cover property (internal_pwm_active);
  c_off: cover property (!converter_on);
endmodule : blc_cfg_chk

bind blc_config_regs blc_cfg_chk blc_cfg_chk_inst (.clk, .arst_n,
  .scl_in, .sda_out, .sda_oe, .string_enable, .amplitude_active,
  .internal_pwm_active, .recover_auto, .short_volts, .converter_on,
  .freq_step_100k);

`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the configuration register bank
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'h3C; // Arbitrary maker code
  logic clk, arst_n, m_oe, scl, sda, a, src, ea, ei, on;
  logic sda_out, sda_oe, amp, ipwm, rec, con;
  logic [5:0] fault_in;
  logic [9:0] ext_duty, dim_level, d;
  logic [3:0] str_en, volts, fstep, fc;
  logic [7:0] v, fsc, ptc;
  logic [1:0] md;
  logic [7:0] dflt [7] = '{8'hF0, 8'h44, 8'h3B, 8'h03, 8'h7F, 8'hE7, ID};
  int miscompares, n_checks;

  // Wired-AND data line with pull-up
  assign sda = (sda_oe ? sda_out : 1'b1) & ~m_oe;

  blc_config_regs #(.MAKER_CODE(ID)) blc_config_regs_inst (.clk(clk),
    .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .fault_in(fault_in), .ext_duty_code(ext_duty),
    .string_enable(str_en), .amplitude_active(amp),
    .internal_pwm_active(ipwm), .dim_level(dim_level),
    .recover_auto(rec), .short_volts(volts), .converter_on(con),
    .freq_step_100k(fstep), .full_scale_code(fsc),
    .prot_thresh_code(ptc));

  blc_bus_master blc_bus_master_inst (.clk(clk), .sda(sda), .scl(scl),
    .sda_oe(m_oe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [9:0] e,
                     input logic [9:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Register write, n bytes from the low end of d, pointer advancing
  task automatic wr(input logic [7:0] idx, input logic [15:0] d,
                    input int n);
    blc_bus_master_inst.start();
    blc_bus_master_inst.send(8'h62, a);
    chk("write ack", 10'h1, 10'(a));
    blc_bus_master_inst.send(idx, a);
    for (int k = n - 1; k >= 0; k--) blc_bus_master_inst.send(d[8*k +: 8], a);
    blc_bus_master_inst.stop();
  endtask : wr

  // Register read through a repeated start
  task automatic rd(input logic [7:0] idx, output logic [7:0] r);
    blc_bus_master_inst.start();
    blc_bus_master_inst.send(8'h62, a);
    blc_bus_master_inst.send(idx, a);
    blc_bus_master_inst.start();
    blc_bus_master_inst.send(8'h63, a);
    chk("read ack", 10'h1, 10'(a));
    blc_bus_master_inst.recv(r, 1'b1);
    blc_bus_master_inst.stop();
  endtask : rd

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // Watchdog well beyond the expected run of about 200 us
  initial begin
    #400000;
    miscompares++;
    give_verdict();
  end

  initial begin
    arst_n = 1'b0;
    fault_in = 6'h00;
    ext_duty = 10'h100;
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    // Power-up values; reserved bit 3 masked on read
    for (int i = 0; i < 7; i++) begin
      rd(8'(i), v);
      v = v & (i == 0 ? 8'hF7 : 8'hFF); // Reserved bit 3 is not relied on
      chk("reg default", 10'(dflt[i]), 10'(v));
    end
    chk("full_scale_code", 10'h03B, 10'(fsc));
    chk("prot_thresh_code", 10'h0E7, 10'(ptc));
    $display("test defaults done");
    // Foreign address must go unanswered
    blc_bus_master_inst.start();
    blc_bus_master_inst.send(8'h64, a);
    blc_bus_master_inst.stop();
    chk("foreign ack", 10'h0, 10'(a));
    $display("test address done");
    // Every mode, both sources; duties at, just below or just past the transfer points
    for (int i = 0; i < 8; i++) begin
      md = i[1:0];
      src = i[2];
      // Odd modes on the external source take a duty just past the 50 percent point
      d = src ? 10'h1FF : (md[0] ? 10'h201 : 10'h100);
      ext_duty = d;
      wr(8'h00, {8'h00, i[3:0] ^ 4'hA, ~i[0], src, md}, 1);
      ea = md == 2'h1 || (md == 2'h2 && d > 10'h100) ||
           (md == 2'h3 && d > 10'h200);
      ei = (md == 2'h0 && src) || (md[1] && !ea);
      chk("string_enable", 10'(i[3:0] ^ 4'hA), 10'(str_en));
      chk("dim_level", d, dim_level);
      chk("amplitude", 10'(ea), 10'(amp));
      chk("internal pwm", 10'(ei), 10'(ipwm));
    end
    $display("test modes done");
    // Frequency codes through off, 1 to 9 and one past the top
    for (int i = 0; i < 11; i++) begin
      fc = i[3:0];
      wr(8'h01, {8'h00, i[1], fc[2:0] ^ 3'h5, fc}, 1);
      on = fc != 4'h0 && fc <= 4'h9;
      chk("recover_auto", 10'(i[1]), 10'(rec));
      chk("short_volts", 10'(4'h4 + {1'b0, fc[2:0] ^ 3'h5}),
          10'(volts));
      chk("converter_on", 10'(on), 10'(con));
      chk("freq_step", on ? 10'(fc) : 10'h0, 10'(fstep));
    end
    $display("test frequency done");
    // Split brightness, live faults, read-only maker code, slow master
    blc_bus_master_inst.q = 12;
    fault_in = 6'h29;
    wr(8'h03, 16'hFE81, 2);
    wr(8'h06, 16'h0000, 1);
    wr(8'h00, 16'h00F5, 1);
    chk("dim_level", 10'h206, dim_level);
    chk("amplitude", 10'h1, 10'(amp));
    wr(8'h02, 16'h0096, 1);
    wr(8'h05, 16'h5AC6, 2); // Second byte meets the read-only index
    chk("full_scale_code", 10'h096, 10'(fsc));
    chk("prot_thresh_code", 10'h05A, 10'(ptc));
    rd(8'h03, v);
    chk("fault reg", 10'h0A6, 10'(v));
    rd(8'h04, v);
    chk("brightness high", 10'h081, 10'(v));
    rd(8'h06, v);
    chk("maker code", 10'(ID), 10'(v));
    rd(8'h07, v);
    chk("unmapped read", 10'h000, 10'(v));
    $display("test brightness done");
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
